// file: logic/edm_pkg.sv
// Constants, register map and state type of the Ethernet descriptor manager.
// Assumes a single pclk domain; all users write edm_pkg::name.
// Operation
// - Filter on: rejected packet reports class 00; late reject may still use descriptors
// - Class field may be undefined for packets shorter than six bytes
// - Oversize bit 22: over 1518 bytes, or over 2046 with long frames accepted
// - Undersize bit 21 when packet including CRC is below 64 bytes
// - Bad symbol bit 20 on invalid line symbol, only at 100 Mb/s
// - Checksum error bit 19 when appended CRC fails
// - Alignment error bit 18 when length is not whole octets
// - Loopback bit 17 for packets from loopback transmission
// - Reception clash bit 16 when collision seen during reception
// - Single-descriptor packet has chain_continues cleared
// - Multi-descriptor packet has chain_continues set except in last descriptor
// - Descriptors chain through link field; ring allowed; any count of packets
// - Enable written while idle fetches current descriptor, or only its link (refresh) when done flag set
// - Descriptor store holds exactly one fragment pointer and count
// - Fifo-wait stalls until space exceeds fill level
// - Intermediate descriptor status written back, waiting for completion
// - Advance is transitory; follows non-null link
// - Refresh re-reads only link field of completed descriptor and waits
// - Descriptor pointer is a 32-bit register
// - Done flag set on completion, cleared on any pointer load; a software load in the null-link cycle leaves it set
// - Track bytes left in descriptor and fragment cursor
// - Fifo space is capacity minus fifo level in bytes
// - Class encodes 01 unicast, 10 multicast, 11 broadcast
// - Fragment burst is min of space and bytes left; bytes left reduced
// - Null link: set done, raise idle interrupt, clear enable, go idle
package edm_pkg;
  // APB register byte offsets
  localparam logic [7:0] ADDR_COMMAND   = 8'h00;
  localparam logic [7:0] ADDR_TX_DESC_POINTER      = 8'h04;
  localparam logic [7:0] ADDR_FILL      = 8'h08;
  localparam logic [7:0] ADDR_STATUS    = 8'h0C;
  localparam logic [7:0] ADDR_RX_CONFIG = 8'h10;
  localparam logic [7:0] ADDR_RX_STATUS = 8'h14;
  // Command and config bits
  localparam int CMD_TXE_BIT   = 0;
  localparam int CFG_ALP_BIT   = 0;
  localparam int CFG_FILT_BIT  = 1;
  // Receive status bit positions
  localparam int ST_CLASS_LO   = 23;
  localparam int ST_OVERSIZE   = 22;
  localparam int ST_UNDERSIZE  = 21;
  localparam int ST_BAD_SYMBOL = 20;
  localparam int ST_CHECKSUM   = 19;
  localparam int ST_ALIGN      = 18;
  localparam int ST_LOOPBACK   = 17;
  localparam int ST_CLASH      = 16;
  // Descriptor command_status_word fields
  localparam int CSW_OWN       = 31;
  localparam int CSW_MORE      = 30;
  localparam int SIZE_W        = 12;
  // Length limits in bytes
  localparam logic [15:0] LEN_MAX_STD   = 16'h05EE;  // 1518
  localparam logic [15:0] LEN_MAX_LONG  = 16'h07FE;  // 2046
  localparam logic [15:0] LEN_MIN       = 16'h0040;  // 64
  // Destination classes
  localparam logic [1:0] CLASS_REJECT = 2'h0;
  localparam logic [1:0] CLASS_UNI    = 2'h1;
  localparam logic [1:0] CLASS_MULTI  = 2'h2;
  localparam logic [1:0] CLASS_BCAST  = 2'h3;
  localparam logic [15:0] FILL_RESET  = 16'h0020;
  localparam logic [31:0] LINK_NULL   = 32'h0000_0000;
  // Bus request kinds
  localparam logic [1:0] REQ_DESC  = 2'h0;
  localparam logic [1:0] REQ_LINK  = 2'h1;
  localparam logic [1:0] REQ_FRAG  = 2'h2;
  localparam logic [1:0] REQ_WBACK = 2'h3;
  typedef enum logic [2:0] {
    TX_IDLE, TX_REFRESH, TX_DESC_READ, TX_FIFO_WAIT,
    TX_FRAG_READ, TX_DESC_WRITE, TX_ADVANCE
  } edm_tx_state_type;
endpackage

// file: logic/edm_desc_store.sv
// Descriptor store: one link, one command_status_word, one fragment pointer.
// Assumes loads come from the transmit machine on the pclk domain.
`timescale 1ns/1ns
module edm_desc_store (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        load_desc,
  input  wire logic        load_link,
  input  wire logic [31:0] in_link,
  input  wire logic [31:0] in_csw,
  input  wire logic [31:0] in_frag,
  output logic      [31:0] link_q,
  output logic      [31:0] csw_q,
  output logic      [31:0] frag_q
);
  // Single pointer/count pair, overwritten per descriptor
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      link_q <= 32'h0000_0000;
      csw_q  <= 32'h0000_0000;
      frag_q <= 32'h0000_0000;
    end else if (load_desc) begin
      link_q <= in_link;
      csw_q  <= in_csw;
      frag_q <= in_frag;
    end else if (load_link) begin
      link_q <= in_link;
    end
  end
endmodule // edm_desc_store

// file: logic/edm_rx_status.sv
// Receive status word builder from per-packet observations.
// Assumes inputs are stable in the cycle pkt_end pulses.
`timescale 1ns/1ns
module edm_rx_status (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        pkt_end,
  input  wire logic [15:0] pkt_len,
  input  wire logic        accept_long_frames,
  input  wire logic        filter_en,
  input  wire logic        rejected,
  input  wire logic [1:0]  target_class_kind,
  input  wire logic        speed_100,
  input  wire logic        symbol_err,
  input  wire logic        crc_bad,
  input  wire logic        dribble,
  input  wire logic        from_loopback,
  input  wire logic        collision,
  output logic      [31:0] status_q
);
  logic [31:0] status_d;
  // Compose status bits
  always_comb begin
    status_d = 32'h0000_0000;
    status_d[edm_pkg::ST_CLASS_LO +: 2] = (filter_en && rejected) ?
      edm_pkg::CLASS_REJECT : target_class_kind;
    status_d[edm_pkg::ST_OVERSIZE] = accept_long_frames ?
      (pkt_len > edm_pkg::LEN_MAX_LONG) : (pkt_len > edm_pkg::LEN_MAX_STD);
    status_d[edm_pkg::ST_UNDERSIZE]  = pkt_len < edm_pkg::LEN_MIN;
    status_d[edm_pkg::ST_BAD_SYMBOL] = speed_100 && symbol_err;
    status_d[edm_pkg::ST_CHECKSUM]   = crc_bad;
    status_d[edm_pkg::ST_ALIGN]      = dribble;
    status_d[edm_pkg::ST_LOOPBACK]   = from_loopback;
    status_d[edm_pkg::ST_CLASH]      = collision;
  end
  // Latch at packet end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) status_q <= 32'h0000_0000;
    else if (pkt_end) status_q <= status_d;
  end
  AST_RUNT: assert property (@(posedge pclk) disable iff (!presetn)
    pkt_end && pkt_len < edm_pkg::LEN_MIN |=> status_q[edm_pkg::ST_UNDERSIZE])
    else $error("undersize bit missing");
  AST_LONG: assert property (@(posedge pclk) disable iff (!presetn)
    pkt_end && !accept_long_frames && pkt_len > edm_pkg::LEN_MAX_STD
    |=> status_q[edm_pkg::ST_OVERSIZE])
    else $error("oversize bit missing");
  AST_REJ: assert property (@(posedge pclk) disable iff (!presetn)
    pkt_end && filter_en && rejected
    |=> status_q[edm_pkg::ST_CLASS_LO +: 2] == edm_pkg::CLASS_REJECT)
    else $error("reject class wrong");
endmodule // edm_rx_status

// file: logic/edm_top.sv
// Transmit descriptor manager with APB registers and receive status.
// Assumes a bus-master engine answering requests with bus_transfer_done.
//
// Chosen here: the APB interface to the registers and the register offsets.
`timescale 1ns/1ns
module edm_top #(
  parameter int FIFO_BYTES = 2048
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             bus_req,
  output logic      [1:0]  bus_kind,
  output logic      [31:0] bus_addr,
  output logic      [15:0] bus_len,
  output logic      [31:0] bus_wdata,
  input  wire logic        bus_transfer_done,
  input  wire logic [31:0] bus_rd_link,
  input  wire logic [31:0] bus_rd_csw,
  input  wire logic [31:0] bus_rd_frag,
  input  wire logic [15:0] tx_fifo_level,
  output logic             tx_idle_interrupt,
  input  wire logic        rx_pkt_end,
  input  wire logic [15:0] rx_pkt_len,
  input  wire logic        rx_rejected,
  input  wire logic [1:0]  rx_target_class_kind,
  input  wire logic        rx_speed_100,
  input  wire logic        rx_symbol_err,
  input  wire logic        rx_crc_bad,
  input  wire logic        rx_dribble,
  input  wire logic        rx_loopback,
  input  wire logic        rx_collision
);
  ////////////////////////////////////////////////////////////////////////////
  edm_pkg::edm_tx_state_type state_q;
  logic        transmit_enable_cmd_q;
  logic [31:0] tx_desc_pointer_q;
  logic        current_desc_done_flag_q;
  logic [15:0] tx_fill_level_q;
  logic [1:0]  rx_config_q;
  logic [15:0] desc_bytes_left_q;
  logic [31:0] fragment_cursor_q;
  logic [15:0] burst_q;
  logic [31:0] link_q;
  logic [31:0] csw_q;
  logic [31:0] frag_q;
  logic [31:0] rx_status_q;
  logic [15:0] tx_fifo_space;
  logic        fifo_space_event;
  logic [15:0] burst_len;
  logic        wr_acc;
  logic        rd_acc;
  logic        ld_desc;
  logic        ld_link;
  logic        done_desc;
  logic        done_frag;
  logic        adv_next;
  logic        adv_null;
  logic        host_tx_desc_pointer_wr;
  logic        host_txe_wr;

  // Decode for an APB address match, reused for reads and writes
  function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
    return a == r;
  endfunction

  // Smaller of two byte counts
  function automatic logic [15:0] min16(input logic [15:0] a, input logic [15:0] b);
    return (a < b) ? a : b;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // APB slave: zero wait states, unmapped reads return zero with error
  assign pready  = 1'b1;
  assign wr_acc  = psel && penable && pwrite;
  assign rd_acc  = psel && !pwrite;
  assign pslverr = psel && penable && !(hit(paddr, edm_pkg::ADDR_COMMAND) ||
                   hit(paddr, edm_pkg::ADDR_TX_DESC_POINTER) || hit(paddr, edm_pkg::ADDR_FILL) ||
                   hit(paddr, edm_pkg::ADDR_STATUS) || hit(paddr, edm_pkg::ADDR_RX_CONFIG) ||
                   hit(paddr, edm_pkg::ADDR_RX_STATUS));
  assign host_tx_desc_pointer_wr = wr_acc && hit(paddr, edm_pkg::ADDR_TX_DESC_POINTER);
  assign host_txe_wr  = wr_acc && hit(paddr, edm_pkg::ADDR_COMMAND) &&
                        pwdata[edm_pkg::CMD_TXE_BIT];

  // Read data registered in the setup cycle so it is stable in access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (rd_acc && !penable) begin
      case (paddr)
        edm_pkg::ADDR_COMMAND:   prdata <= {31'h0, transmit_enable_cmd_q};
        edm_pkg::ADDR_TX_DESC_POINTER:      prdata <= tx_desc_pointer_q;
        edm_pkg::ADDR_FILL:      prdata <= {16'h0, tx_fill_level_q};
        edm_pkg::ADDR_STATUS:    prdata <= {12'h0, desc_bytes_left_q,
                                            current_desc_done_flag_q, state_q};
        edm_pkg::ADDR_RX_CONFIG: prdata <= {30'h0, rx_config_q};
        edm_pkg::ADDR_RX_STATUS: prdata <= rx_status_q;
        default:                 prdata <= 32'h0000_0000;
      endcase
    end
  end

  // Software configuration registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_fill_level_q <= edm_pkg::FILL_RESET;
      rx_config_q     <= 2'h0;
    end else if (wr_acc) begin
      if (hit(paddr, edm_pkg::ADDR_FILL)) tx_fill_level_q <= pwdata[15:0];
      if (hit(paddr, edm_pkg::ADDR_RX_CONFIG)) rx_config_q <= pwdata[1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Fifo space and burst sizing
  assign tx_fifo_space    = 16'(FIFO_BYTES) - tx_fifo_level;
  assign fifo_space_event = tx_fifo_space > tx_fill_level_q;
  assign burst_len        = min16(tx_fifo_space, desc_bytes_left_q);

  // State transition events
  assign ld_desc   = state_q == edm_pkg::TX_DESC_READ && bus_transfer_done;
  assign ld_link   = state_q == edm_pkg::TX_REFRESH && bus_transfer_done;
  assign done_desc = state_q == edm_pkg::TX_FIFO_WAIT && desc_bytes_left_q == 16'h0;
  assign done_frag = state_q == edm_pkg::TX_FIFO_WAIT && !done_desc && fifo_space_event;
  assign adv_next  = state_q == edm_pkg::TX_ADVANCE && link_q != edm_pkg::LINK_NULL;
  assign adv_null  = state_q == edm_pkg::TX_ADVANCE && link_q == edm_pkg::LINK_NULL;

  // Transmit state machine
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= edm_pkg::TX_IDLE;
    end else begin
      case (state_q)
        edm_pkg::TX_IDLE:
          if (transmit_enable_cmd_q)
            state_q <= current_desc_done_flag_q ? edm_pkg::TX_REFRESH
                                                : edm_pkg::TX_DESC_READ;
        edm_pkg::TX_REFRESH:
          if (bus_transfer_done) state_q <= edm_pkg::TX_ADVANCE;
        edm_pkg::TX_DESC_READ:
          if (bus_transfer_done)
            state_q <= bus_rd_csw[edm_pkg::CSW_OWN] ? edm_pkg::TX_FIFO_WAIT
                                                    : edm_pkg::TX_IDLE;
        edm_pkg::TX_FIFO_WAIT:
          if (done_desc)
            state_q <= csw_q[edm_pkg::CSW_MORE] ? edm_pkg::TX_DESC_WRITE
                                                : edm_pkg::TX_ADVANCE;
          else if (fifo_space_event) state_q <= edm_pkg::TX_FRAG_READ;
        edm_pkg::TX_FRAG_READ:
          if (bus_transfer_done) state_q <= edm_pkg::TX_FIFO_WAIT;
        edm_pkg::TX_DESC_WRITE:
          if (bus_transfer_done) state_q <= edm_pkg::TX_ADVANCE;
        edm_pkg::TX_ADVANCE:
          state_q <= adv_next ? edm_pkg::TX_DESC_READ : edm_pkg::TX_IDLE;
        default: state_q <= edm_pkg::TX_IDLE;
      endcase
    end
  end

  // Enable command: software sets, null link clears
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) transmit_enable_cmd_q <= 1'b0;
    else if (host_txe_wr) transmit_enable_cmd_q <= 1'b1; // set wins over clear
    else if (adv_null) transmit_enable_cmd_q <= 1'b0;
  end

  // Descriptor pointer: software load or follow link
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) tx_desc_pointer_q <= 32'h0000_0000;
    else if (host_tx_desc_pointer_wr) tx_desc_pointer_q <= pwdata;
    else if (adv_next) tx_desc_pointer_q <= link_q;
  end

  // Done flag: set on null link, cleared by any pointer load not in a null-link cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) current_desc_done_flag_q <= 1'b0;
    else if (adv_null) current_desc_done_flag_q <= 1'b1;
    else if (host_tx_desc_pointer_wr || adv_next) current_desc_done_flag_q <= 1'b0;
  end

  // Byte count and fragment cursor
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      desc_bytes_left_q <= 16'h0000;
      fragment_cursor_q <= 32'h0000_0000;
      burst_q           <= 16'h0000;
    end else if (ld_desc) begin
      desc_bytes_left_q <= {4'h0, bus_rd_csw[edm_pkg::SIZE_W-1:0]};
      fragment_cursor_q <= bus_rd_frag;
    end else if (done_frag) begin
      desc_bytes_left_q <= desc_bytes_left_q - burst_len;
      burst_q           <= burst_len;
    end else if (state_q == edm_pkg::TX_FRAG_READ && bus_transfer_done) begin
      fragment_cursor_q <= fragment_cursor_q + {16'h0, burst_q};
    end
  end

  // Idle interrupt pulse on null link or unowned descriptor
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) tx_idle_interrupt <= 1'b0;
    else tx_idle_interrupt <= adv_null ||
                              (ld_desc && !bus_rd_csw[edm_pkg::CSW_OWN]);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bus request outputs held while waiting in a bus state
  always_comb begin
    bus_req   = 1'b0;
    bus_kind  = edm_pkg::REQ_DESC;
    bus_addr  = tx_desc_pointer_q;
    bus_len   = 16'h0000;
    bus_wdata = 32'h0000_0000;
    case (state_q)
      edm_pkg::TX_DESC_READ: bus_req = 1'b1;
      edm_pkg::TX_REFRESH: begin
        bus_req  = 1'b1;
        bus_kind = edm_pkg::REQ_LINK;
      end
      edm_pkg::TX_FRAG_READ: begin
        bus_req  = 1'b1;
        bus_kind = edm_pkg::REQ_FRAG;
        bus_addr = fragment_cursor_q;
        bus_len  = burst_q;
      end
      edm_pkg::TX_DESC_WRITE: begin
        bus_req   = 1'b1;
        bus_kind  = edm_pkg::REQ_WBACK;
        bus_wdata = csw_q & ~(32'h1 << edm_pkg::CSW_OWN);
      end
      default: bus_req = 1'b0;
    endcase
  end

  edm_desc_store u_store (
    .pclk      (pclk),
    .presetn   (presetn),
    .load_desc (ld_desc),
    .load_link (ld_link),
    .in_link   (bus_rd_link),
    .in_csw    (bus_rd_csw),
    .in_frag   (bus_rd_frag),
    .link_q    (link_q),
    .csw_q     (csw_q),
    .frag_q    (frag_q)
  );

  edm_rx_status u_rx (
    .pclk               (pclk),
    .presetn            (presetn),
    .pkt_end            (rx_pkt_end),
    .pkt_len            (rx_pkt_len),
    .accept_long_frames (rx_config_q[edm_pkg::CFG_ALP_BIT]),
    .filter_en          (rx_config_q[edm_pkg::CFG_FILT_BIT]),
    .rejected           (rx_rejected),
    .target_class_kind          (rx_target_class_kind),
    .speed_100          (rx_speed_100),
    .symbol_err         (rx_symbol_err),
    .crc_bad            (rx_crc_bad),
    .dribble            (rx_dribble),
    .from_loopback      (rx_loopback),
    .collision          (rx_collision),
    .status_q           (rx_status_q)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  AST_ADV_TRANSIENT: assert property (@(posedge pclk) disable iff (!presetn)
    state_q == edm_pkg::TX_ADVANCE |=> state_q != edm_pkg::TX_ADVANCE)
    else $error("advance held");
  AST_NULL_IDLE: assert property (@(posedge pclk) disable iff (!presetn)
    adv_null |=> state_q == edm_pkg::TX_IDLE && current_desc_done_flag_q &&
    tx_idle_interrupt)
    else $error("null link handling wrong");
  AST_TX_DESC_POINTER_CLR: assert property (@(posedge pclk) disable iff (!presetn)
    host_tx_desc_pointer_wr && !adv_null |=> !current_desc_done_flag_q)
    else $error("done flag not cleared");
  AST_WAIT_STALL: assert property (@(posedge pclk) disable iff (!presetn)
    state_q == edm_pkg::TX_FIFO_WAIT && !fifo_space_event && desc_bytes_left_q != 16'h0
    |=> state_q == edm_pkg::TX_FIFO_WAIT)
    else $error("left fifo wait early");
  AST_BURST: assert property (@(posedge pclk) disable iff (!presetn)
    done_frag |=> burst_q == $past(burst_len) &&
    desc_bytes_left_q == $past(desc_bytes_left_q) - $past(burst_len))
    else $error("burst sizing wrong");
  AST_FRAG_BACK: assert property (@(posedge pclk) disable iff (!presetn)
    state_q == edm_pkg::TX_FRAG_READ && bus_transfer_done
    |=> state_q == edm_pkg::TX_FIFO_WAIT)
    else $error("frag read exit wrong");
  AST_START: assert property (@(posedge pclk) disable iff (!presetn)
    state_q == edm_pkg::TX_IDLE && transmit_enable_cmd_q && !current_desc_done_flag_q
    |=> state_q == edm_pkg::TX_DESC_READ)
    else $error("no descriptor fetch");
  AST_STORE: assert property (@(posedge pclk) disable iff (!presetn)
    ld_desc |=> frag_q == fragment_cursor_q)
    else $error("store and cursor disagree");
  AST_SPACE: assert property (@(posedge pclk) disable iff (!presetn)
    tx_fifo_space + tx_fifo_level == 16'(FIFO_BYTES))
    else $error("space mismatch");
  AST_WBACK: assert property (@(posedge pclk) disable iff (!presetn)
    done_desc && csw_q[edm_pkg::CSW_MORE] |=> bus_req && bus_kind == edm_pkg::REQ_WBACK)
    else $error("no write back");
  COV_REFRESH: cover property (@(posedge pclk) state_q == edm_pkg::TX_REFRESH);
  COV_WBACK:   cover property (@(posedge pclk) state_q == edm_pkg::TX_DESC_WRITE);
  COV_NEXT:    cover property (@(posedge pclk) adv_next);
endmodule // edm_top

// file: verification/edm_host_model.sv
// Host memory model answering the descriptor manager's bus-master requests.
// Assumes the bench loads descriptor slots and latency; slot is bus_addr[5:4].
`timescale 1ns/1ns
module edm_host_model (
  input  wire logic        pclk,
  input  wire logic        bus_req,
  input  wire logic [1:0]  bus_kind,
  input  wire logic [31:0] bus_addr,
  input  wire logic [31:0] bus_wdata,
  output logic             bus_transfer_done,
  output logic      [31:0] bus_rd_link,
  output logic      [31:0] bus_rd_csw,
  output logic      [31:0] bus_rd_frag
);
  logic [31:0] link_m [4];
  logic [31:0] csw_m  [4];
  logic [31:0] frag_m [4];
  logic [31:0] l_q = 32'h0;
  logic [31:0] c_q = 32'h0;
  logic [31:0] f_q = 32'h0;
  int          dly = 0;  // Answer latency in cycles
  int          cnt = 0;
  initial bus_transfer_done = 1'b0;
  // Answer after dly cycles, one-cycle done pulse
  always @(posedge pclk) begin
    bus_transfer_done <= 1'b0;
    if (bus_req && !bus_transfer_done) begin
      if (cnt >= dly) begin
        cnt <= 0;
        bus_transfer_done <= 1'b1;
        l_q <= link_m[bus_addr[5:4]];
        c_q <= csw_m[bus_addr[5:4]];
        f_q <= frag_m[bus_addr[5:4]];
        if (bus_kind == edm_pkg::REQ_WBACK) csw_m[bus_addr[5:4]] <= bus_wdata;
      end else cnt <= cnt + 1;
    end
  end
  // Stale words inverted so nothing latches them by luck
  assign bus_rd_link = bus_transfer_done ? l_q : ~l_q;
  assign bus_rd_csw  = bus_transfer_done ? c_q : ~c_q;
  assign bus_rd_frag = bus_transfer_done ? f_q : ~f_q;
endmodule // edm_host_model

// file: verification/test_ethernet_descriptor_manager.sv
// Self-checking bench: APB master, receive status table, transmit chain walk.
// Assumes edm_top with FIFO_BYTES 256 and the host model on the bus side.
`timescale 1ns/1ns
module test_ethernet_descriptor_manager;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, bus_addr, bus_wdata, rd;
  logic [31:0] bus_rd_link, bus_rd_csw, bus_rd_frag;
  logic        pready, pslverr, bus_req, bus_transfer_done, tx_idle_interrupt, err;
  logic [1:0]  bus_kind, rx_target_class_kind = 2'h0;
  logic [15:0] bus_len, tx_fifo_level = 16'h00E0, rx_pkt_len = 16'h0000;
  logic        rx_pkt_end = 1'b0, rx_rejected = 1'b0, rx_speed_100 = 1'b0, rx_symbol_err = 1'b0;
  logic        rx_crc_bad = 1'b0, rx_dribble = 1'b0, rx_loopback = 1'b0, rx_collision = 1'b0;
  logic [49:0] log_q [$];
  int          failures = 0, n_tests = 0, cyc = 0, n_irq = 0;
  // Rows: length, {long ok, rejected, class, 100M, symbol, crc, dribble, loop, clash}, bits 24:16
  localparam logic [34:0] ROWS [12] = '{
    {16'h05EE, 10'h040, 9'h080}, {16'h05EF, 10'h080, 9'h140}, {16'h07FE, 10'h2C0, 9'h180},
    {16'h07FF, 10'h240, 9'h0C0}, {16'h003F, 10'h040, 9'h0A0}, {16'h0040, 10'h140, 9'h000},
    {16'h0064, 10'h050, 9'h080}, {16'h0064, 10'h070, 9'h090}, {16'h0064, 10'h048, 9'h088},
    {16'h0064, 10'h044, 9'h084}, {16'h0064, 10'h042, 9'h082}, {16'h0064, 10'h041, 9'h081}};
  // Expected transfers: kind, address (write data for writeback), burst length
  localparam logic [49:0] TXEXP [11] = '{
    {2'h0, 32'h10, 16'h0}, {2'h2, 32'h1000, 16'h00C0}, {2'h2, 32'h10C0, 16'h0040},
    {2'h3, 32'h4000_0100, 16'h0}, {2'h0, 32'h20, 16'h0}, {2'h2, 32'h2000, 16'h0050},
    {2'h1, 32'h20, 16'h0}, {2'h0, 32'h30, 16'h0}, {2'h2, 32'h3000, 16'h0010},
    {2'h0, 32'h30, 16'h0}, {2'h2, 32'h3000, 16'h0010}};
  edm_top #(.FIFO_BYTES(256)) DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .bus_req, .bus_kind, .bus_addr, .bus_len, .bus_wdata,
    .bus_transfer_done, .bus_rd_link, .bus_rd_csw, .bus_rd_frag, .tx_fifo_level,
    .tx_idle_interrupt, .rx_pkt_end, .rx_pkt_len, .rx_rejected, .rx_target_class_kind, .rx_speed_100,
    .rx_symbol_err, .rx_crc_bad, .rx_dribble, .rx_loopback, .rx_collision);
  edm_host_model HOST (.pclk, .bus_req, .bus_kind, .bus_addr, .bus_wdata, .bus_transfer_done,
    .bus_rd_link, .bus_rd_csw, .bus_rd_frag);
  ////////////////////////////////////////////////////////////////////////////////////////
  // Clock, timeout, mid-cycle monitor
  initial forever #25 pclk = ~pclk;
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      end_sim();
    end
  end
  // Sampled at negedge so comb bus_req and the done pulse are settled
  always @(negedge pclk) begin
    if (bus_req === 1'b1 && bus_transfer_done === 1'b1)
      log_q.push_back({bus_kind, (bus_kind == 2'h3) ? bus_wdata : bus_addr, bus_len});
    if (tx_idle_interrupt === 1'b1) n_irq++;
  end
  ////////////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // Setup, access until pready, take data at that edge, release
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic set_desc(input int s, input logic [31:0] l, c, f);
    HOST.link_m[s] = l;
    HOST.csw_m[s] = c;
    HOST.frag_m[s] = f;
  endtask
  task automatic tx_wait(input int n);
    while (n_irq < n) @(posedge pclk);
    repeat (2) @(posedge pclk);
  endtask
  task automatic end_sim();
    if (failures == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, edm_pkg::ADDR_FILL, 32'h0);
    chk("fill_reset", rd, {16'h0, edm_pkg::FILL_RESET});
    apb(1'b0, edm_pkg::ADDR_STATUS, 32'h0);
    chk("status_reset", rd, 32'h0);
    apb(1'b0, 8'h40, 32'h0);
    chk("unmapped_err", err, 32'h1);
    chk("unmapped_data", rd, 32'h0);
    for (int i = 0; i < 12; i++) begin
      apb(1'b1, edm_pkg::ADDR_RX_CONFIG, {30'h0, 1'b1, ROWS[i][18]});
      rx_pkt_len <= ROWS[i][34:19];
      {rx_rejected, rx_target_class_kind, rx_speed_100, rx_symbol_err, rx_crc_bad, rx_dribble,
       rx_loopback, rx_collision} <= ROWS[i][17:9];
      rx_pkt_end <= 1'b1;
      @(posedge pclk);
      rx_pkt_end <= 1'b0;
      apb(1'b0, edm_pkg::ADDR_RX_STATUS, 32'h0);
      chk("rx_status", {23'h0, rd[24:16]}, {23'h0, ROWS[i][8:0]});
    end
    set_desc(1, 32'h20, 32'hC000_0100, 32'h1000);
    set_desc(2, 32'h0, 32'h8000_0050, 32'h2000);
    set_desc(3, 32'h0, 32'h8000_0010, 32'h3000);
    HOST.dly = 2;
    apb(1'b1, edm_pkg::ADDR_TX_DESC_POINTER, 32'h10);
    apb(1'b1, edm_pkg::ADDR_COMMAND, 32'h1);
    while (log_q.size() < 1) @(posedge pclk);
    repeat (20) @(posedge pclk);
    apb(1'b0, edm_pkg::ADDR_STATUS, 32'h0);
    chk("fifo_wait_state", rd[2:0], 32'h3);
    chk("no_early_burst", log_q.size(), 32'h1);
    tx_fifo_level <= 16'h0040;
    tx_wait(1);
    apb(1'b0, edm_pkg::ADDR_STATUS, 32'h0);
    chk("done_after_null", rd[3], 32'h1);
    apb(1'b0, edm_pkg::ADDR_COMMAND, 32'h0);
    chk("enable_cleared", rd[0], 32'h0);
    set_desc(2, 32'h30, 32'h8000_0050, 32'h2000);
    HOST.dly = 0;
    apb(1'b1, edm_pkg::ADDR_COMMAND, 32'h1);
    tx_wait(2);
    apb(1'b1, edm_pkg::ADDR_TX_DESC_POINTER, 32'h30);
    apb(1'b0, edm_pkg::ADDR_STATUS, 32'h0);
    chk("done_cleared", rd[3], 32'h0);
    apb(1'b1, edm_pkg::ADDR_COMMAND, 32'h1);
    tx_wait(3);
    chk("irq_count", n_irq, 32'h3);
    chk("transfer_count", log_q.size(), 32'd11);
    for (int i = 0; i < 11; i++) begin
      chk("bus_kind", log_q[i][49:48], TXEXP[i][49:48]);
      chk("bus_addr", log_q[i][47:16], TXEXP[i][47:16]);
      if (TXEXP[i][49:48] == 2'h2) chk("bus_len", log_q[i][15:0], TXEXP[i][15:0]);
    end
    end_sim();
  end
endmodule // test_ethernet_descriptor_manager
